// *** pkg/mac_map.svh ***
// Purpose: offsets, field positions, encodings and reset values of the
//          mac slice
// Assumes: 16-bit register port, word indexed
// Notes:   definitions only
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define REG_X0        5'h00
`define REG_Y0        5'h01
`define REG_Y1        5'h02
`define REG_ACC_BASE  5'h03
`define REG_ACC_STEP  5'h03
`define REG_OMR       5'h0F
`define REG_SR        5'h10
`define REG_R0        5'h11
`define REG_R1        5'h12
`define REG_R3        5'h13
`define REG_N         5'h14

// ****************************************************************
// fields and reset values
// ****************************************************************
`define OMR_SA        4
`define OMR_R         5
`define OMR_XP        8
`define CCR_C         0
`define CCR_V         1
`define CCR_Z         2
`define CCR_N         3
`define CCR_U         4
`define CCR_E         5
`define CCR_L         6
`define CCR_SZ        7
`define OMR_RST       16'h0000
`define CCR_RST       8'h00
`define ACC_RST       36'h0_0000_0000
`define WORD_RST      16'h0000

// ****************************************************************
// opcodes
// ****************************************************************
`define MIXED_SIGN_MAC_TOP     5'h0E
`define MIXED_SIGN_MAC_LOW     4'hE
`define FRACTIONAL_MAC_ROUND_TOP      6'h1E
`define FRACTIONAL_MAC_ROUND_LOW      3'h2
`define DEST_BAD      3'h7
`define ROUND_HALF    37'h0_0000_8000
`define LSP_HALF      16'h8000
`define OP_CYCLES     1

`endif

// *** pkg/mac_pkg.sv ***
// Purpose: types shared by the mac slice and its users
// Assumes: constants live in mac_map.svh
// Notes:   one packed struct holds all slice state
package mac_pkg;

  typedef enum logic [1:0]
  {
    OP_NONE  = 2'b00,
    OP_FRACTIONAL_MAC_ROUND  = 2'b01,
    OP_MIXED_SIGN_MAC = 2'b10,
    OP_BAD   = 2'b11
  } op_kind_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic [15:0] rd1_data;
    logic [15:0] rd2_data;
  } mac_cmd_s;

  typedef struct packed {
    logic [15:0]       x0;
    logic [15:0]       y0;
    logic [15:0]       y1;
    logic [3:0][35:0]  acc;
    logic [15:0]       operating_mode_reg;
    logic [7:0]        condition_code_byte;
    logic [15:0]       r0;
    logic [15:0]       r1;
    logic [15:0]       r3;
    logic [15:0]       nreg;
    logic [15:0]       rdata;
    logic              done;
    logic              illegal;
  } core_state_s;

endpackage : mac_pkg

// *** hdl/mac_arith.sv ***
// Purpose: fractional multiply, 36-bit accumulate and optional rounding
// Assumes: purely combinational, used inside the clocked slice
// Notes:   product kept at full width so no bits fall off before the add
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_arith #(
  parameter int ACC_W = 36,
  parameter int OP_W  = 16
) (
  input  wire logic [OP_W-1:0]  src_signed,
  input  wire logic [OP_W-1:0]  src_second,
  input  wire logic             second_unsigned,
  input  wire logic             round_en,
  input  wire logic             round_twos,
  input  wire logic [ACC_W-1:0] acc_in,
  output logic      [ACC_W-1:0] result,
  output logic                  overflow
);

  logic signed [OP_W:0]     s2x;
  logic signed [2*OP_W+1:0] prod;
  logic        [ACC_W:0]    prod_x;
  logic        [ACC_W:0]    sum;
  logic        [ACC_W:0]    rnd;

  // second source widened by one bit, zero or sign
  assign s2x = second_unsigned ? $signed({1'b0, src_second})
             : $signed({src_second[OP_W-1], src_second});
  assign prod = $signed(src_signed) * s2x;
  // fractional shift, then sign extension to the adder width
  assign prod_x = {{(ACC_W-2*OP_W-1){prod[2*OP_W+1]}},
                   prod[2*OP_W:0], 1'b0};
  assign sum = {acc_in[ACC_W-1], acc_in} + prod_x;

  always_comb
  begin
    rnd = sum;
    if (round_en)
    begin
      rnd = sum + `ROUND_HALF;
      // exact half goes to even under convergent rounding
      if (!round_twos && sum[OP_W-1:0] == `LSP_HALF)
        rnd[OP_W] = 1'b0;
      rnd[OP_W-1:0] = '0;
    end
  end

  assign result   = rnd[ACC_W-1:0];
  assign overflow = rnd[ACC_W] ^ rnd[ACC_W-1];

endmodule : mac_arith

// *** hdl/mac_slice.sv ***
// Purpose: data alu slice for the mixed-sign mac and the dual-read
//          rounding mac, with its registers and condition flags
// Assumes: cmd and reg_req come from logic on clk_sys; memory answers
//          the pointer outputs in the same cycle as cmd.valid
// Notes:   one instruction per cycle, no stall, no saturation
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_slice (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire mac_pkg::reg_req_s   reg_req,
  output logic [15:0]              rd_data,
  input  wire mac_pkg::mac_cmd_s   cmd,
  output logic [15:0]              ptr_r0,
  output logic [15:0]              ptr_r1,
  output logic [15:0]              ptr_r3,
  output logic [7:0]               ccr_out,
  output logic [15:0]              omr_out,
  output logic                     op_done,
  output logic                     op_illegal
);

  // ****************************************************************
  // state
  // ****************************************************************
  mac_pkg::core_state_s state_ff;
  mac_pkg::core_state_s nxt_state;
  mac_pkg::op_kind_e    kind;

  logic [15:0] src_a;
  logic [15:0] src_b;
  logic        src_uns;
  logic [35:0] dest_val;
  logic [2:0]  dest_sel;
  logic [35:0] mac_res;
  logic        mac_ovf;
  logic [15:0] rd_val;
  logic [15:0] w;

  assign w = cmd.word;

  // ****************************************************************
  // flag update shared by both operations
  // ****************************************************************
  function automatic logic [7:0] upd_ccr(
    input logic [7:0]  old,
    input logic [35:0] r,
    input logic        ovf
  );
    logic [7:0] c;
    c            = old;
    c[`CCR_V]    = ovf;
    c[`CCR_L]    = old[`CCR_L] | ovf;
    c[`CCR_E]    = !((&r[35:31]) || !(|r[35:31]));
    c[`CCR_U]    = (r[31] == r[30]);
    c[`CCR_N]    = r[35];
    c[`CCR_Z]    = (r == 36'h0_0000_0000);
    return c;
  endfunction : upd_ccr

  // 16-bit register widened to a 36-bit accumulate operand
  function automatic logic [35:0] widen(input logic [15:0] v);
    return {{4{v[15]}}, v, 16'h0000};
  endfunction : widen

  // ****************************************************************
  // decode
  // ****************************************************************
  always_comb
  begin
    kind = mac_pkg::OP_NONE;
    if (cmd.valid)
    begin
      if (w[15:11] == `MIXED_SIGN_MAC_TOP && w[10] && w[3:0] == `MIXED_SIGN_MAC_LOW)
      begin
        kind = (w[9:7] == `DEST_BAD) ? mac_pkg::OP_BAD
             : mac_pkg::OP_MIXED_SIGN_MAC;
      end
      else if (w[15:10] == `FRACTIONAL_MAC_ROUND_TOP && w[2:0] == `FRACTIONAL_MAC_ROUND_LOW)
      begin
        // no dual-read mac while code runs from data memory
        kind = state_ff.operating_mode_reg[`OMR_XP] ? mac_pkg::OP_BAD
             : mac_pkg::OP_FRACTIONAL_MAC_ROUND;
      end
      else
      begin
        kind = mac_pkg::OP_BAD;
      end
    end
  end

  // ****************************************************************
  // operand and destination selection
  // ****************************************************************
  always_comb
  begin
    src_a    = state_ff.x0;
    src_b    = state_ff.y1;
    src_uns  = 1'b0;
    dest_sel = 3'h0;
    if (kind == mac_pkg::OP_MIXED_SIGN_MAC)
    begin
      src_uns  = 1'b1;
      dest_sel = w[9:7];
      case (w[6:4])
        3'h0:
        begin
          src_a = state_ff.x0;
          src_b = state_ff.y1;
        end
        3'h1:
        begin
          src_a = state_ff.x0;
          src_b = state_ff.y0;
        end
        3'h2:
        begin
          src_a = state_ff.y0;
          src_b = state_ff.y1;
        end
        3'h3:
        begin
          src_a = state_ff.y0;
          src_b = state_ff.y0;
        end
        3'h4:
        begin
          src_a = state_ff.y0;
          src_b = state_ff.acc[0][31:16];
        end
        3'h5:
        begin
          src_a = state_ff.y1;
          src_b = state_ff.acc[1][31:16];
        end
        3'h6:
        begin
          src_a = state_ff.y0;
          src_b = state_ff.acc[2][31:16];
        end
        default:
        begin
          src_a = state_ff.y1;
          src_b = state_ff.acc[2][31:16];
        end
      endcase
    end
    else
    begin
      dest_sel = {2'b00, w[9]};
      case (w[8:7])
        2'h0:
        begin
          src_a = state_ff.y1;
          src_b = state_ff.x0;
        end
        2'h1:
        begin
          src_a = state_ff.y1;
          src_b = state_ff.y0;
        end
        2'h2:
        begin
          src_a = state_ff.y0;
          src_b = state_ff.x0;
        end
        default:
        begin
          src_a = state_ff.acc[2][31:16];
          src_b = state_ff.y0;
        end
      endcase
    end
  end

  always_comb
  begin
    case (dest_sel)
      3'h0, 3'h1, 3'h2, 3'h3: dest_val = state_ff.acc[dest_sel[1:0]];
      3'h4:    dest_val = widen(state_ff.x0);
      3'h5:    dest_val = widen(state_ff.y0);
      3'h6:    dest_val = widen(state_ff.y1);
      default: dest_val = `ACC_RST;
    endcase
  end

  mac_arith #(
    .ACC_W (36),
    .OP_W  (16)
  ) u_arith (
    .src_signed      (src_a),
    .src_second      (src_b),
    .second_unsigned (src_uns),
    .round_en        (kind == mac_pkg::OP_FRACTIONAL_MAC_ROUND),
    .round_twos      (state_ff.operating_mode_reg[`OMR_R]),
    .acc_in          (dest_val),
    .result          (mac_res),
    .overflow        (mac_ovf)
  );

  // ****************************************************************
  // register read mux
  // ****************************************************************
  always_comb
  begin
    rd_val = `WORD_RST;
    case (reg_req.addr)
      `REG_X0:  rd_val = state_ff.x0;
      `REG_Y0:  rd_val = state_ff.y0;
      `REG_Y1:  rd_val = state_ff.y1;
      `REG_OMR: rd_val = state_ff.operating_mode_reg;
      `REG_SR:  rd_val = {8'h00, state_ff.condition_code_byte};
      `REG_R0:  rd_val = state_ff.r0;
      `REG_R1:  rd_val = state_ff.r1;
      `REG_R3:  rd_val = state_ff.r3;
      `REG_N:   rd_val = state_ff.nreg;
      default:  rd_val = `WORD_RST;
    endcase
    for (int i = 0; i < 4; i++)
    begin
      if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i))
        rd_val = {12'h000, state_ff.acc[i][35:32]};
      if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i + 1))
        rd_val = state_ff.acc[i][31:16];
      if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i + 2))
        rd_val = state_ff.acc[i][15:0];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    nxt_state         = state_ff;
    nxt_state.rdata   = `WORD_RST;
    nxt_state.done    = 1'b0;
    nxt_state.illegal = 1'b0;

    if (reg_req.rd)
      nxt_state.rdata = rd_val;

    // software writes first so that a same-cycle instruction wins
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `REG_X0:  nxt_state.x0   = reg_req.wdata;
        `REG_Y0:  nxt_state.y0   = reg_req.wdata;
        `REG_Y1:  nxt_state.y1   = reg_req.wdata;
        `REG_OMR: nxt_state.operating_mode_reg  = reg_req.wdata;
        `REG_SR:  nxt_state.condition_code_byte  = reg_req.wdata[7:0];
        `REG_R0:  nxt_state.r0   = reg_req.wdata;
        `REG_R1:  nxt_state.r1   = reg_req.wdata;
        `REG_R3:  nxt_state.r3   = reg_req.wdata;
        `REG_N:   nxt_state.nreg = reg_req.wdata;
        default:  nxt_state.nreg = nxt_state.nreg;
      endcase
      for (int i = 0; i < 4; i++)
      begin
        if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i))
          nxt_state.acc[i][35:32] = reg_req.wdata[3:0];
        if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i + 1))
          nxt_state.acc[i][31:16] = reg_req.wdata;
        if (reg_req.addr == 5'(`REG_ACC_BASE + `REG_ACC_STEP * i + 2))
          nxt_state.acc[i][15:0] = reg_req.wdata;
      end
    end

    case (kind)
      mac_pkg::OP_MIXED_SIGN_MAC:
      begin
        // result stored as computed, saturation bit not consulted
        case (dest_sel)
          3'h4:    nxt_state.x0 = mac_res[31:16];
          3'h5:    nxt_state.y0 = mac_res[31:16];
          3'h6:    nxt_state.y1 = mac_res[31:16];
          default: nxt_state.acc[dest_sel[1:0]] = mac_res;
        endcase
        nxt_state.condition_code_byte  = upd_ccr(nxt_state.condition_code_byte, mac_res, mac_ovf);
        nxt_state.done = 1'b1;
      end
      mac_pkg::OP_FRACTIONAL_MAC_ROUND:
      begin
        // arithmetic, both reads and both post-updates in one cycle
        nxt_state.acc[dest_sel[1:0]] = mac_res;
        nxt_state.condition_code_byte = upd_ccr(nxt_state.condition_code_byte, mac_res, mac_ovf);
        if (w[4])
          nxt_state.y1 = cmd.rd1_data;
        else
          nxt_state.y0 = cmd.rd1_data;
        nxt_state.x0 = cmd.rd2_data;
        case (w[6:5])
          2'h0:    nxt_state.r0 = state_ff.r0 + 16'h0001;
          2'h1:    nxt_state.r0 = state_ff.r0 + state_ff.nreg;
          2'h2:    nxt_state.r1 = state_ff.r1 + 16'h0001;
          default: nxt_state.r1 = state_ff.r1 + state_ff.nreg;
        endcase
        nxt_state.r3 = w[3] ? state_ff.r3 - 16'h0001
                     : state_ff.r3 + 16'h0001;
        nxt_state.done = 1'b1;
      end
      mac_pkg::OP_BAD:
      begin
        // refused word leaves every register untouched
        nxt_state.illegal = 1'b1;
      end
      default:
      begin
        nxt_state.done = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_ff.x0      <= `WORD_RST;
      state_ff.y0      <= `WORD_RST;
      state_ff.y1      <= `WORD_RST;
      state_ff.acc     <= {4{`ACC_RST}};
      state_ff.operating_mode_reg     <= `OMR_RST;
      state_ff.condition_code_byte     <= `CCR_RST;
      state_ff.r0      <= `WORD_RST;
      state_ff.r1      <= `WORD_RST;
      state_ff.r3      <= `WORD_RST;
      state_ff.nreg    <= `WORD_RST;
      state_ff.rdata   <= `WORD_RST;
      state_ff.done    <= 1'b0;
      state_ff.illegal <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // outputs, each a flip-flop
  // ****************************************************************
  assign rd_data    = state_ff.rdata;
  assign ptr_r0     = state_ff.r0;
  assign ptr_r1     = state_ff.r1;
  assign ptr_r3     = state_ff.r3;
  assign ccr_out    = state_ff.condition_code_byte;
  assign omr_out    = state_ff.operating_mode_reg;
  assign op_done    = state_ff.done;
  assign op_illegal = state_ff.illegal;

endmodule : mac_slice

// *** testbench/mac_slice_assertions.sv ***
// Purpose: port-level checks of the mac slice
// Assumes: one clock, reset asynchronous and active high
// Notes:   bound onto every mac_slice instance
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_slice_checker (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire mac_pkg::reg_req_s reg_req,
  input wire logic [15:0]       rd_data,
  input wire mac_pkg::mac_cmd_s cmd,
  input wire logic [15:0]       ptr_r0,
  input wire logic [15:0]       ptr_r1,
  input wire logic [15:0]       ptr_r3,
  input wire logic [7:0]        ccr_out,
  input wire logic [15:0]       omr_out,
  input wire logic              op_done,
  input wire logic              op_illegal
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ****************************************************************
  // instruction issue
  // ****************************************************************
  sequence fractional_mac_round_issue;
    cmd.valid && cmd.word[15:10] == 6'h1E && cmd.word[2:0] == 3'h2;
  endsequence
  sequence mixed_sign_mac_issue;
    cmd.valid && cmd.word[15:10] == 6'h1D && cmd.word[3:0] == 4'hE;
  endsequence

  one_answer_a: assert property (cmd.valid |=> op_done != op_illegal)
    else $error("issued word got no single answer");
  quiet_idle_a: assert property (!cmd.valid |=> !op_done && !op_illegal)
    else $error("answer without an issued word");
  xp_refuse_a: assert property (fractional_mac_round_issue ##0 omr_out[8]
    |=> op_illegal && $stable(ptr_r0)) else $error("fractional_mac_round ran from data mem");
  fractional_mac_round_update_a: assert property (fractional_mac_round_issue ##0 !omr_out[8] |=> op_done &&
    (ptr_r3 == $past(ptr_r3) + 16'h0001 || ptr_r3 == $past(ptr_r3) - 16'h0001))
    else $error("fractional_mac_round pointer not updated in one cycle");
  mixed_sign_mac_accept_a: assert property (mixed_sign_mac_issue ##0 cmd.word[9:7] != 3'h7
    |=> op_done) else $error("legal mixed-sign mac refused");
  bad_dest_a: assert property (mixed_sign_mac_issue ##0 cmd.word[9:7] == 3'h7
    |=> op_illegal && $stable(ccr_out)) else $error("bad dest accepted");

  // ****************************************************************
  // flags
  // ****************************************************************
  sticky_limit_a: assert property (ccr_out[6] &&
    !(reg_req.wr && reg_req.addr == `REG_SR) |=> ccr_out[6])
    else $error("limit flag dropped");
  v_sets_l_a: assert property ($rose(ccr_out[1]) |-> ccr_out[6])
    else $error("overflow without limit flag");
  zero_flags_a: assert property (op_done && ccr_out[2]
    |-> !ccr_out[3] && ccr_out[4] && !ccr_out[5])
    else $error("zero result with inconsistent flags");
endmodule : mac_slice_checker

bind mac_slice mac_slice_checker chk_u (
  .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
  .cmd(cmd), .ptr_r0(ptr_r0), .ptr_r1(ptr_r1), .ptr_r3(ptr_r3),
  .ccr_out(ccr_out), .omr_out(omr_out), .op_done(op_done),
  .op_illegal(op_illegal)
);

// *** testbench/mac_slice_bench.sv ***
// Purpose: directed self-checking bench of the mac slice
// Assumes: register port answers reads one cycle later
// Notes:   memory read data are handed in with each issued word
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_slice_bench;
  logic              clk_sys;
  logic              reset;
  mac_pkg::reg_req_s reg_req;
  mac_pkg::mac_cmd_s cmd;
  logic [15:0]       rd_data;
  logic [15:0]       ptr_r0;
  logic [15:0]       ptr_r1;
  logic [15:0]       ptr_r3;
  logic [7:0]        ccr_out;
  logic [15:0]       omr_out;
  logic              op_done;
  logic              op_illegal;
  int                miscompares = 0;
  int                cmp_count = 0;

  mac_slice dut_u (
    .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
    .cmd(cmd), .ptr_r0(ptr_r0), .ptr_r1(ptr_r1), .ptr_r3(ptr_r3),
    .ccr_out(ccr_out), .omr_out(omr_out), .op_done(op_done),
    .op_illegal(op_illegal)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input string what, input logic [35:0] seen,
                       input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp,
                        input string what);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    check(what, rd_data, exp);
  endtask : reg_rd

  // answer pulse stands only in the cycle after the issue edge
  task automatic issue(input logic [15:0] w, input logic [15:0] d1,
                       input logic [15:0] d2, input logic ok);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, word: w, rd1_data: d1, rd2_data: d2};
    @(posedge clk_sys);
    cmd <= '0;
    #1;
    check("op_done", op_done, ok);
    check("op_illegal", op_illegal, !ok);
  endtask : issue

  task automatic set_acc(input logic [4:0] b, input logic [15:0] e,
                         input logic [15:0] m, input logic [15:0] l);
    reg_wr(b, e);
    reg_wr(b + 5'h01, m);
    reg_wr(b + 5'h02, l);
  endtask : set_acc

  task automatic chk_acc(input logic [4:0] b, input logic [3:0] e,
                         input logic [15:0] m, input logic [15:0] l);
    reg_rd(b, {12'h000, e}, "acc ext");
    reg_rd(b + 5'h01, m, "acc mid");
    reg_rd(b + 5'h02, l, "acc low");
  endtask : chk_acc

  task automatic test_done();
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    reg_req = '0;
    cmd = '0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    reg_rd(`REG_X0, 16'h0000, "x0 reset");
    reg_rd(`REG_OMR, 16'h0000, "omr reset");
    reg_rd(`REG_SR, 16'h0000, "sr reset");
    reg_wr(`REG_X0, 16'h1234);
    reg_rd(`REG_X0, 16'h1234, "x0 rw");
    reg_rd(5'h1F, 16'h0000, "unmapped");
    // convergent then two's complement, second pass decrements r3
    for (int i = 0; i < 2; i++)
    begin
      reg_wr(`REG_OMR, {10'h000, i[0], 5'h00});
      set_acc(5'h03, 16'h0000, 16'h0000, 16'h8000);
      reg_wr(`REG_Y0, 16'h0200);
      reg_wr(`REG_X0, 16'h0280);
      reg_wr(`REG_R0, 16'h0100);
      reg_wr(`REG_R3, 16'h0200);
      issue({12'h790, i[0], 3'h2}, 16'h0300, 16'h0288, 1'b1);
      check("ptr_r0", ptr_r0, 16'h0101);
      check("ptr_r3", ptr_r3, i ? 16'h01FF : 16'h0201);
      check("ccr", ccr_out, 8'h10);
      chk_acc(5'h03, 4'h0, i ? 16'h000B : 16'h000A, 16'h0000);
      reg_rd(`REG_Y0, 16'h0300, "y0 read1");
      reg_rd(`REG_X0, 16'h0288, "x0 read2");
    end
    reg_wr(`REG_OMR, 16'h0100);
    issue(16'h7902, 16'h5555, 16'h6666, 1'b0);
    check("omr_out", omr_out, 16'h0100);
    check("ptr_r0 held", ptr_r0, 16'h0101);
    reg_rd(`REG_X0, 16'h0288, "x0 held");
    reg_wr(`REG_OMR, 16'h0000);
    // r1 plus offset into y1, c1 times y0 into b, tie goes to even
    reg_wr(`REG_Y0, 16'h2000);
    reg_wr(`REG_R1, 16'h0400);
    reg_wr(`REG_N, 16'h0010);
    set_acc(5'h09, 16'h0000, 16'h4000, 16'h0000);
    set_acc(5'h06, 16'h0000, 16'h0002, 16'h8000);
    issue(16'h7BF2, 16'h1111, 16'h2222, 1'b1);
    check("ptr_r1", ptr_r1, 16'h0410);
    check("ptr_r3 inc", ptr_r3, 16'h0200);
    check("ccr", ccr_out, 8'h10);
    chk_acc(5'h06, 4'h0, 16'h1002, 16'h0000);
    reg_rd(`REG_Y1, 16'h1111, "y1 read1");
    reg_rd(`REG_X0, 16'h2222, "x0 read2");
    // signed y1 times unsigned b1 into a
    reg_wr(`REG_Y1, 16'hFFF4);
    set_acc(5'h06, 16'h0000, 16'h0002, 16'h3456);
    set_acc(5'h03, 16'h0000, 16'h0000, 16'h0020);
    issue(16'h745E, 16'h0000, 16'h0000, 1'b1);
    chk_acc(5'h03, 4'hF, 16'hFFFF, 16'hFFF0);
    check("ccr", ccr_out, 8'h18);
    reg_rd(`REG_SR, 16'h0018, "sr flags");
    // 0xFFFF second source must count as unsigned
    reg_wr(`REG_X0, 16'h8000);
    reg_wr(`REG_Y1, 16'hFFFF);
    set_acc(5'h06, 16'h0000, 16'h0000, 16'h0000);
    issue(16'h748E, 16'h0000, 16'h0000, 1'b1);
    chk_acc(5'h06, 4'hF, 16'h0001, 16'h0000);
    check("ccr", ccr_out, 8'h38);
    // overflow with saturation enabled: no clamp
    reg_wr(`REG_OMR, 16'h0010);
    set_acc(5'h03, 16'h0007, 16'hFFFF, 16'hFFFF);
    reg_wr(`REG_Y0, 16'h7FFF);
    issue(16'h743E, 16'h0000, 16'h0000, 1'b1);
    chk_acc(5'h03, 4'h8, 16'h7FFE, 16'h0001);
    check("ccr", ccr_out, 8'h6A);
    // 16-bit destination keeps upper word, limit stays sticky
    reg_wr(`REG_Y1, 16'hFFF4);
    issue(16'h773E, 16'h0000, 16'h0000, 1'b1);
    reg_rd(`REG_Y1, 16'h7FF2, "y1 dest");
    check("ccr", ccr_out, 8'h40);
    set_acc(5'h09, 16'h0000, 16'h0000, 16'h0000);
    issue(16'h756E, 16'h0000, 16'h0000, 1'b1);
    chk_acc(5'h09, 4'h0, 16'h0000, 16'h0000);
    check("ccr", ccr_out, 8'h54);
    issue(16'h778E, 16'h0000, 16'h0000, 1'b0);
    issue(16'h0000, 16'h0000, 16'h0000, 1'b0);
    check("ccr held", ccr_out, 8'h54);
    test_done();
  end

  initial
  begin
    #(20 * 4000);
    miscompares++;
    test_done();
  end
endmodule : mac_slice_bench
